// file: include/cocc_defs.vh
// register offsets, field positions, reset values and codes of the output stage
`ifndef COCC_DEFS_VH
`define COCC_DEFS_VH

// register byte offsets
`define COCC_OFS_CHAN_PD 8'h00
`define COCC_OFS_ROUTE 8'h04
`define COCC_OFS_CLK_PD 8'h08
`define COCC_OFS_CLK_EN 8'h0C
`define COCC_OFS_CLK_AMP 8'h10
`define COCC_OFS_REF_CTL 8'h14
`define COCC_OFS_REF_AMP 8'h18
`define COCC_OFS_REF_DLY 8'h1C
`define COCC_OFS_DIV 8'h20
`define COCC_OFS_SDIV 8'h24
`define COCC_OFS_PH_LO 8'h28
`define COCC_OFS_PH_HI 8'h2C
`define COCC_OFS_STATUS 8'h30

// field positions in the sysref control register
`define COCC_REF_PD_LSB 0
`define COCC_REF_EN_LSB 8
`define COCC_REF_BIAS_LSB 16

// status register fields
`define COCC_ST_ACT_LSB 0
`define COCC_ST_SEQ_BIT 8
`define COCC_ST_CLK_LSB 16

// route selector values
`define COCC_ROUTE_CLOCK 1'b0
`define COCC_ROUTE_SYSREF 1'b1

// amplitude codes: 250, 500, 750 and 1000 mV swing
`define COCC_AMP_250 2'h0
`define COCC_AMP_500 2'h1
`define COCC_AMP_750 2'h2
`define COCC_AMP_1000 2'h3

// reset values
`define COCC_RST_CHAN_PD 5'h00
`define COCC_RST_ROUTE 8'h00
`define COCC_RST_CLK_PD 10'h000
`define COCC_RST_CLK_EN 10'h000
`define COCC_RST_CLK_AMP 20'h55555
`define COCC_RST_REF_PD 8'h00
`define COCC_RST_REF_EN 8'h00
`define COCC_RST_REF_BIAS 8'h00
`define COCC_RST_REF_AMP 16'h5555
`define COCC_RST_REF_DLY 24'h000000
`define COCC_RST_DIV 20'h11111
`define COCC_RST_SDIV 8'h01
`define COCC_RST_PH 40'h0000000000

`endif

// file: rtl/cocc_div.v
// integer divider producing a toggling output level
`timescale 1ns/100ps
module cocc_div #(
  parameter W = 4
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // divide value, zero behaves as one
  input wire [W-1:0] div_i,
  // divided level
  output wire q_o
);

reg [W-1:0] cnt_r;
reg q_r;
wire [W-1:0] last = (div_i == {W{1'b0}}) ? {W{1'b0}} : div_i - {{(W-1){1'b0}}, 1'b1};

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    cnt_r <= {W{1'b0}};
    q_r <= 1'b0;
  end
  else if (cnt_r >= last)
  begin
    // half period is div_i cycles of the vco clock
    cnt_r <= {W{1'b0}};
    q_r <= ~q_r;
  end
  else
    cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
end

assign q_o = q_r;

endmodule

// file: rtl/cocc_out.v
// state, source, delay and amplitude logic of one output
`timescale 1ns/100ps
`include "cocc_defs.vh"
module cocc_out (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // configuration
  input wire route_i,
  input wire pd_i,
  input wire chan_pd_i,
  input wire en_i,
  input wire bias_i,
  input wire [1:0] amp_i,
  input wire [7:0] chan_ph_i,
  input wire [2:0] ref_dly_i,
  // sources
  input wire chan_clk_i,
  input wire sref_clk_i,
  input wire seq_active_i,
  // output state
  output reg lvl_o,
  output reg pwr_o,
  output reg mid_o,
  output reg [1:0] amp_o,
  output reg [7:0] dly_o
);

wire sref = (route_i == `COCC_ROUTE_SYSREF); // [RULE1]
// sysref mode: channel scope power, sequencer decides activity
wire pwr = sref ? ~chan_pd_i : ~pd_i; // [RULE7] [RULE4]
wire act = sref ? seq_active_i : en_i; // [RULE11] [RULE3] [RULE8]
wire src = sref ? sref_clk_i : chan_clk_i; // [RULE5]

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    lvl_o <= 1'b0;
    pwr_o <= 1'b0;
    mid_o <= 1'b0;
    amp_o <= `COCC_AMP_250;
    dly_o <= 8'h00;
  end
  else
  begin
    pwr_o <= pwr; // [RULE9]
    lvl_o <= pwr & act & src; // [RULE9]
    mid_o <= pwr & sref & bias_i & ~seq_active_i; // [RULE12]
    amp_o <= amp_i; // [RULE10]
    dly_o <= sref ? {5'h00, ref_dly_i} : chan_ph_i; // [RULE6]
  end
end

endmodule

// file: rtl/cocc_top.v
// channel and output configuration of the clock output stage, wishbone slave
`timescale 1ns/100ps
`include "cocc_defs.vh"

// Summary of operation
// [RULE1] Each sysref-capable output carries the channel clock when its route bit is 0 and sysref when 1.
// [RULE2] Channels A to D hold one to three clock and sysref-capable outputs, channel E two clock outputs only.
// [RULE3] A sysref-routed output switches on when a sysref sequence starts and off after it without software.
// [RULE4] A clock-routed sysref-capable output takes its state only from its own settings.
// [RULE5] Clock routing uses the channel divider, sysref routing the one shared sysref divider.
// [RULE6] Clock routing uses the channel phase delay, sysref routing the output's own sysref delay.
// [RULE7] Power down exists per channel and per output, sysref-routed outputs obey the channel bit.
// [RULE8] Every clock and sysref-capable output has its own enable bit.
// [RULE9] Power down 1 means off, enable 0 means static low, enable 1 means toggling.
// [RULE10] Each output has a two-bit amplitude code for 250, 500, 750 or 1000 mV.
// [RULE11] For a sysref-routed output the sequencer, not the enable bit, decides activity.
// [RULE12] A sysref output with idle bias set rests at line midpoint instead of static low.
module cocc_top #(
  parameter DIV_W = 4,
  parameter SDIV_W = 8
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // sysref sequencer
  input wire seq_active_i,
  // clock outputs A0 A1 A2 B0 B1 C0 C1 D E0 E1
  output wire [9:0] clock_output_o,
  output wire [9:0] clock_output_pwr_o,
  output wire [19:0] clock_output_amp_o,
  output wire [79:0] clock_output_dly_o,
  // sysref-capable outputs A0 A1 A2 B0 B1 C0 C1 D
  output wire [7:0] sysref_capable_output_o,
  output wire [7:0] sysref_capable_output_pwr_o,
  output wire [7:0] sysref_capable_output_mid_o,
  output wire [15:0] sysref_capable_output_amp_o,
  output wire [63:0] sysref_capable_output_dly_o
);

////////////////////////////////////////////////////////////////////////////////
// output to channel map, index 0 is A0

localparam [29:0] CH_MAP = {3'h4, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0}; // [RULE2]
localparam N_CH = 5;
localparam N_CLK = 10;
localparam N_REF = 8;

////////////////////////////////////////////////////////////////////////////////
// configuration registers

reg [4:0] chan_pd_r;
reg [7:0] route_r;
reg [9:0] clk_pd_r;
reg [9:0] clk_en_r;
reg [19:0] clk_amp_r;
reg [7:0] ref_pd_r;
reg [7:0] ref_en_r;
reg [7:0] ref_bias_r;
reg [15:0] ref_amp_r;
reg [23:0] ref_dly_r;
reg [19:0] div_r;
reg [7:0] sdiv_r;
reg [39:0] ph_r;

////////////////////////////////////////////////////////////////////////////////
// bus decode

// writes land at the taking edge, so outputs follow one edge after it
wire req = cyc_i & stb_i;
wire wr = req & we_i & ~ack_o;
wire rd = req & ~we_i & ~ack_o;
wire [7:0] ofs = {adr_i[7:2], 2'b00};

// byte-lane merge of write data into an old word
function [31:0] merge;
  input [31:0] old;
  input [31:0] d;
  input [3:0] s;
  integer i;
  begin
    merge = old;
    for (i = 0; i < 4; i = i + 1)
    begin
      if (s[i])
        merge[i*8 +: 8] = d[i*8 +: 8];
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// register writes

wire [31:0] w_chan_pd = merge({27'h0, chan_pd_r}, dat_i, sel_i);
wire [31:0] w_route = merge({24'h0, route_r}, dat_i, sel_i);
wire [31:0] w_clk_pd = merge({22'h0, clk_pd_r}, dat_i, sel_i);
wire [31:0] w_clk_en = merge({22'h0, clk_en_r}, dat_i, sel_i);
wire [31:0] w_clk_amp = merge({12'h0, clk_amp_r}, dat_i, sel_i);
wire [31:0] ref_ctl = {8'h0, ref_bias_r, ref_en_r, ref_pd_r};
wire [31:0] w_ref_ctl = merge(ref_ctl, dat_i, sel_i);
wire [31:0] w_ref_amp = merge({16'h0, ref_amp_r}, dat_i, sel_i);
wire [31:0] w_ref_dly = merge({8'h0, ref_dly_r}, dat_i, sel_i);
wire [31:0] w_div = merge({12'h0, div_r}, dat_i, sel_i);
wire [31:0] w_sdiv = merge({24'h0, sdiv_r}, dat_i, sel_i);
wire [31:0] w_ph_lo = merge(ph_r[31:0], dat_i, sel_i);
wire [31:0] w_ph_hi = merge({24'h0, ph_r[39:32]}, dat_i, sel_i);

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    chan_pd_r <= `COCC_RST_CHAN_PD;
    route_r <= `COCC_RST_ROUTE;
    clk_pd_r <= `COCC_RST_CLK_PD;
    clk_en_r <= `COCC_RST_CLK_EN;
    clk_amp_r <= `COCC_RST_CLK_AMP;
    ref_pd_r <= `COCC_RST_REF_PD;
    ref_en_r <= `COCC_RST_REF_EN;
    ref_bias_r <= `COCC_RST_REF_BIAS;
    ref_amp_r <= `COCC_RST_REF_AMP;
    ref_dly_r <= `COCC_RST_REF_DLY;
    div_r <= `COCC_RST_DIV;
    sdiv_r <= `COCC_RST_SDIV;
    ph_r <= `COCC_RST_PH;
  end
  else if (wr)
  begin
    case (ofs)
      `COCC_OFS_CHAN_PD:
        chan_pd_r <= w_chan_pd[4:0]; // [RULE7]
      `COCC_OFS_ROUTE:
        route_r <= w_route[7:0]; // [RULE1]
      `COCC_OFS_CLK_PD:
        clk_pd_r <= w_clk_pd[9:0]; // [RULE7]
      `COCC_OFS_CLK_EN:
        clk_en_r <= w_clk_en[9:0]; // [RULE8]
      `COCC_OFS_CLK_AMP:
        clk_amp_r <= w_clk_amp[19:0]; // [RULE10]
      `COCC_OFS_REF_CTL:
      begin
        ref_pd_r <= w_ref_ctl[`COCC_REF_PD_LSB +: 8];
        ref_en_r <= w_ref_ctl[`COCC_REF_EN_LSB +: 8]; // [RULE8]
        ref_bias_r <= w_ref_ctl[`COCC_REF_BIAS_LSB +: 8]; // [RULE12]
      end
      `COCC_OFS_REF_AMP:
        ref_amp_r <= w_ref_amp[15:0]; // [RULE10]
      `COCC_OFS_REF_DLY:
        ref_dly_r <= w_ref_dly[23:0]; // [RULE6]
      `COCC_OFS_DIV:
        div_r <= w_div[19:0]; // [RULE5]
      `COCC_OFS_SDIV:
        sdiv_r <= w_sdiv[7:0]; // [RULE5]
      `COCC_OFS_PH_LO:
        ph_r[31:0] <= w_ph_lo; // [RULE6]
      `COCC_OFS_PH_HI:
        ph_r[39:32] <= w_ph_hi[7:0];
      default:
        ph_r <= ph_r;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// dividers: one per channel and one shared by all sysref-routed outputs

wire [N_CH-1:0] chan_clk;
wire sref_clk;

genvar g;
generate
  for (g = 0; g < N_CH; g = g + 1)
  begin : g_div
    cocc_div #(
      .W(DIV_W)
    ) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .div_i(div_r[g*4 +: DIV_W]),
      .q_o(chan_clk[g])
    ); // [RULE5]
  end
endgenerate

cocc_div #(
  .W(SDIV_W)
) u_sdiv (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .div_i(sdiv_r[SDIV_W-1:0]),
  .q_o(sref_clk)
); // [RULE5]

////////////////////////////////////////////////////////////////////////////////
// clock outputs: always clock routed, channel power down also applies

// clock outputs have no idle bias, so their midpoint flag is left open
// their sysref source and delay inputs are tied low since they never leave clock routing

generate
  for (g = 0; g < N_CLK; g = g + 1)
  begin : g_clk
    cocc_out u_clk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .route_i(`COCC_ROUTE_CLOCK),
      .pd_i(clk_pd_r[g] | chan_pd_r[CH_MAP[g*3 +: 3]]), // [RULE7]
      .chan_pd_i(chan_pd_r[CH_MAP[g*3 +: 3]]),
      .en_i(clk_en_r[g]), // [RULE8]
      .bias_i(1'b0),
      .amp_i(clk_amp_r[g*2 +: 2]), // [RULE10]
      .chan_ph_i(ph_r[CH_MAP[g*3 +: 3]*8 +: 8]),
      .ref_dly_i(3'h0),
      .chan_clk_i(chan_clk[CH_MAP[g*3 +: 3]]),
      .sref_clk_i(1'b0),
      .seq_active_i(1'b0),
      .lvl_o(clock_output_o[g]), // [RULE9]
      .pwr_o(clock_output_pwr_o[g]),
      .mid_o(),
      .amp_o(clock_output_amp_o[g*2 +: 2]),
      .dly_o(clock_output_dly_o[g*8 +: 8])
    );
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// sysref-capable outputs of channels A to D

generate
  for (g = 0; g < N_REF; g = g + 1)
  begin : g_ref
    cocc_out u_ref (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .route_i(route_r[g]), // [RULE1]
      .pd_i(ref_pd_r[g]), // [RULE4]
      .chan_pd_i(chan_pd_r[CH_MAP[g*3 +: 3]]), // [RULE7]
      .en_i(ref_en_r[g]),
      .bias_i(ref_bias_r[g]), // [RULE12]
      .amp_i(ref_amp_r[g*2 +: 2]),
      .chan_ph_i(ph_r[CH_MAP[g*3 +: 3]*8 +: 8]), // [RULE6]
      .ref_dly_i(ref_dly_r[g*3 +: 3]),
      .chan_clk_i(chan_clk[CH_MAP[g*3 +: 3]]),
      .sref_clk_i(sref_clk),
      .seq_active_i(seq_active_i), // [RULE3] [RULE11]
      .lvl_o(sysref_capable_output_o[g]),
      .pwr_o(sysref_capable_output_pwr_o[g]),
      .mid_o(sysref_capable_output_mid_o[g]),
      .amp_o(sysref_capable_output_amp_o[g*2 +: 2]),
      .dly_o(sysref_capable_output_dly_o[g*8 +: 8])
    );
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// status: which sysref-capable outputs are live right now

// mirrors the activity decision without the divider phase, so software sees a steady value
reg [7:0] ref_live;
integer k;

always @*
begin
  ref_live = 8'h00;
  for (k = 0; k < N_REF; k = k + 1)
  begin
    if (route_r[k])
      ref_live[k] = ~chan_pd_r[CH_MAP[k*3 +: 3]] & seq_active_i; // [RULE11]
    else
      ref_live[k] = ~ref_pd_r[k] & ref_en_r[k]; // [RULE4]
  end
end

wire [31:0] status = {11'h0, chan_clk, 7'h0, seq_active_i, ref_live};

////////////////////////////////////////////////////////////////////////////////
// read mux and acknowledge; unmapped reads return zero and are still acked

reg [31:0] rdata;

always @*
begin
  case (ofs)
    `COCC_OFS_CHAN_PD:
      rdata = {27'h0, chan_pd_r};
    `COCC_OFS_ROUTE:
      rdata = {24'h0, route_r};
    `COCC_OFS_CLK_PD:
      rdata = {22'h0, clk_pd_r};
    `COCC_OFS_CLK_EN:
      rdata = {22'h0, clk_en_r};
    `COCC_OFS_CLK_AMP:
      rdata = {12'h0, clk_amp_r};
    `COCC_OFS_REF_CTL:
      rdata = ref_ctl;
    `COCC_OFS_REF_AMP:
      rdata = {16'h0, ref_amp_r};
    `COCC_OFS_REF_DLY:
      rdata = {8'h0, ref_dly_r};
    `COCC_OFS_DIV:
      rdata = {12'h0, div_r};
    `COCC_OFS_SDIV:
      rdata = {24'h0, sdiv_r};
    `COCC_OFS_PH_LO:
      rdata = ph_r[31:0];
    `COCC_OFS_PH_HI:
      rdata = {24'h0, ph_r[39:32]};
    `COCC_OFS_STATUS:
      rdata = status;
    default:
      rdata = 32'h00000000;
  endcase
end

always @(posedge clk_i)
begin
  if (rst_i)
  begin
    ack_o <= 1'b0;
    dat_o <= 32'h00000000;
  end
  else
  begin
    // one wait state; ack drops the cycle after it was given
    ack_o <= req & ~ack_o;
    if (rd)
      dat_o <= rdata;
  end
end

endmodule

// file: sim/cocc_top_props.sv
// port-level assertions of the output stage configuration
`timescale 1ns/100ps
`include "cocc_defs.vh"
module cocc_top_props (
  // clock, reset and bus
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire ack_o,
  input wire seq_active_i,
  // outputs
  input wire [9:0] clock_output_o,
  input wire [9:0] clock_output_pwr_o,
  input wire [19:0] clock_output_amp_o,
  input wire [7:0] sysref_capable_output_o,
  input wire [7:0] sysref_capable_output_pwr_o,
  input wire [7:0] sysref_capable_output_mid_o,
  input wire [15:0] sysref_capable_output_amp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg [7:0] route_r;
  // shadow of the route register, loaded at the edge the slave takes the write
  always @(posedge clk_i)
  begin
    if (rst_i)
      route_r <= 8'h00;
    else if (cyc_i && stb_i && we_i && !ack_o && {adr_i[7:2], 2'b00} == `COCC_OFS_ROUTE && sel_i[0])
      route_r <= dat_i[7:0];
  end
  //////////////////////////////////////////////////////////////////////////////
  ack_wait_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  clk_off_a: assert property ((clock_output_o & ~clock_output_pwr_o) == 10'h000)
    else $error("clock output live while powered down");
  ref_off_a: assert property ((sysref_capable_output_o & ~sysref_capable_output_pwr_o) == 8'h00)
    else $error("sysref-capable output live while powered down");
  mid_seq_a: assert property (seq_active_i |=> sysref_capable_output_mid_o == 8'h00)
    else $error("midpoint bias held during a sequence");
  mid_pwr_a: assert property ((sysref_capable_output_mid_o & ~sysref_capable_output_pwr_o) == 8'h00)
    else $error("midpoint bias on a powered-down output");
  mid_route_a: assert property ((sysref_capable_output_mid_o & ~$past(route_r)) == 8'h00)
    else $error("midpoint bias on a clock-routed output");
  ref_idle_a: assert property (!seq_active_i [*3] |-> (sysref_capable_output_o & route_r & $past(route_r)) == 8'h00)
    else $error("sysref-routed output active outside a sequence");
  amp_rst_a: assert property ($fell(rst_i) |=> clock_output_amp_o == 20'h55555 && sysref_capable_output_amp_o == 16'h5555)
    else $error("amplitude not at its reset code");
  cover property ($rose(seq_active_i));
  cover property (|sysref_capable_output_mid_o);
  cover property (seq_active_i && |sysref_capable_output_o);
  cover property (ack_o && !we_i);
endmodule

// file: sim/cocc_conv_model.sv
// converter-side receiver: notes which outputs toggled since the last clear
`timescale 1ns/100ps
module cocc_conv_model (
  // clock and control
  input wire clk_i,
  input wire clr_i,
  // received lines
  input wire [9:0] clk_lvl_i,
  input wire [7:0] ref_lvl_i,
  // toggle seen flags
  output reg [9:0] clk_seen_o,
  output reg [7:0] ref_seen_o
);
  reg [9:0] clk_q;
  reg [7:0] ref_q;
  always @(posedge clk_i)
  begin
    clk_q <= clk_lvl_i;
    ref_q <= ref_lvl_i;
    if (clr_i)
      {clk_seen_o, ref_seen_o} <= 18'h00000;
    else
      {clk_seen_o, ref_seen_o} <= {clk_seen_o, ref_seen_o} | {clk_q ^ clk_lvl_i, ref_q ^ ref_lvl_i};
  end
endmodule

// file: sim/testbench.sv
// self-checking bench of the output stage configuration
`timescale 1ns/100ps
`include "cocc_defs.vh"
module testbench;
  reg clk_i, rst_i, cyc, stb, we, seq, clr;
  reg [7:0] adr;
  reg [31:0] wdat, q;
  reg [3:0] sel;
  wire [31:0] rdat;
  wire ack;
  wire [9:0] clk_l, clk_p, clk_s;
  wire [19:0] clk_a;
  wire [7:0] ref_l, ref_p, ref_m, ref_s;
  wire [15:0] ref_a;
  wire [63:0] ref_d;
  wire [79:0] clk_d;
  integer n_fail, n_checks, k;
  reg [7:0] ofs [0:5];
  reg [31:0] rv [0:5];
  cocc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat),
    .sel_i(sel), .dat_o(rdat), .ack_o(ack), .seq_active_i(seq), .clock_output_o(clk_l),
    .clock_output_pwr_o(clk_p), .clock_output_amp_o(clk_a), .clock_output_dly_o(clk_d),
    .sysref_capable_output_o(ref_l), .sysref_capable_output_pwr_o(ref_p),
    .sysref_capable_output_mid_o(ref_m), .sysref_capable_output_amp_o(ref_a), .sysref_capable_output_dly_o(ref_d));
  cocc_conv_model conv (.clk_i(clk_i), .clr_i(clr), .clk_lvl_i(clk_l), .ref_lvl_i(ref_l),
    .clk_seen_o(clk_s), .ref_seen_o(ref_s));
  //////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e)
      begin
        n_fail = n_fail + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // one classic cycle; called and left just after a rising edge
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      n = 0;
      do
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
        n_fail = n_fail + 1;
        wrap_up;
      end
      q = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
    end
  endtask
  // clear the receiver flags, then let eight cycles of traffic pass
  task tg;
    begin
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_fail = n_fail + 1;
    wrap_up;
  end
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, seq, clr} = 5'h00;
    adr = 8'h00;
    wdat = 32'h00000000;
    sel = 4'hF;
    n_fail = 0;
    n_checks = 0;
    ofs = '{`COCC_OFS_CHAN_PD, `COCC_OFS_CLK_AMP, `COCC_OFS_REF_AMP, `COCC_OFS_DIV, `COCC_OFS_SDIV, 8'h34};
    rv = '{32'h00000000, 32'h00055555, 32'h00005555, 32'h00011111, 32'h00000001, 32'h00000000};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("clock amp", clk_a, 32'h00055555);
    for (k = 0; k < 6; k = k + 1)
    begin
      xfer(1'b0, ofs[k], 32'h00000000);
      chk("reset value", q, rv[k]);
    end
    xfer(1'b1, 8'h34, 32'hFFFFFFFF);
    xfer(1'b0, 8'h34, 32'h00000000);
    chk("unmapped", q, 32'h00000000);
    xfer(1'b1, `COCC_OFS_CLK_EN, 32'h000003FF);
    tg;
    chk("clock toggle", clk_s, 32'h000003FF);
    chk("clock power", clk_p, 32'h000003FF);
    xfer(1'b1, `COCC_OFS_CLK_PD, 32'h00000001);
    xfer(1'b1, `COCC_OFS_CHAN_PD, 32'h00000010);
    tg;
    chk("clock power", clk_p, 32'h000000FE);
    chk("clock toggle", clk_s, 32'h000000FE);
    xfer(1'b1, `COCC_OFS_CLK_PD, 32'h00000000);
    xfer(1'b1, `COCC_OFS_CLK_EN, 32'h00000000);
    xfer(1'b1, `COCC_OFS_CHAN_PD, 32'h00000001);
    tg;
    chk("clock toggle", clk_s, 32'h00000000);
    chk("clock level", clk_l, 32'h00000000);
    chk("clock power", clk_p, 32'h000003F8);
    for (k = 0; k < 4; k = k + 1)
    begin
      xfer(1'b1, `COCC_OFS_CLK_AMP, k * 32'h00055555);
      xfer(1'b1, `COCC_OFS_REF_AMP, k * 32'h00005555);
      chk("clock amp", clk_a, k * 32'h00055555);
      chk("sysref amp", ref_a, k * 32'h00005555);
    end
    xfer(1'b1, `COCC_OFS_PH_LO, 32'h44332211);
    xfer(1'b1, `COCC_OFS_REF_DLY, 32'h00FAC688);
    xfer(1'b1, `COCC_OFS_REF_CTL, 32'h0000FF00);
    tg;
    chk("sysref toggle", ref_s, 32'h000000FF);
    chk("sysref power", ref_p, 32'h000000FF);
    chk("delay a0", ref_d[7:0], 32'h00000011);
    chk("delay d", ref_d[63:56], 32'h00000044);
    chk("clock delay a0", clk_d[7:0], 32'h00000011);
    chk("clock delay e0", clk_d[71:64], 32'h00000000);
    xfer(1'b1, `COCC_OFS_ROUTE, 32'h000000FF);
    xfer(1'b1, `COCC_OFS_REF_CTL, 32'h00000000);
    tg;
    chk("sysref toggle", ref_s, 32'h00000000);
    chk("sysref power", ref_p, 32'h000000F8);
    chk("delay a1", ref_d[15:8], 32'h00000001);
    chk("delay d", ref_d[63:56], 32'h00000007);
    chk("clock delay d", clk_d[63:56], 32'h00000044);
    seq <= 1'b1;
    tg;
    chk("sysref toggle", ref_s, 32'h000000F8);
    chk("sysref mid", ref_m, 32'h00000000);
    xfer(1'b0, `COCC_OFS_STATUS, 32'h00000000);
    chk("status", q & 32'h0000FFFF, 32'h000001F8);
    seq <= 1'b0;
    xfer(1'b1, `COCC_OFS_REF_CTL, 32'h00FF0000);
    tg;
    chk("sysref toggle", ref_s, 32'h00000000);
    chk("sysref mid", ref_m, 32'h000000F8);
    xfer(1'b1, `COCC_OFS_ROUTE, 32'h0000000F);
    xfer(1'b1, `COCC_OFS_REF_CTL, 32'h0000FF00);
    tg;
    chk("mixed route", ref_s, 32'h000000F0);
    chk("sysref level", ref_l & 8'h0F, 32'h00000000);
    xfer(1'b0, `COCC_OFS_STATUS, 32'h00000000);
    chk("status", q & 32'h0000FFFF, 32'h000000F0);
    xfer(1'b1, `COCC_OFS_DIV, 32'h00054321);
    xfer(1'b0, `COCC_OFS_DIV, 32'h00000000);
    chk("divider", q, 32'h00054321);
    wrap_up;
  end
endmodule
bind cocc_top cocc_top_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .seq_active_i(seq_active_i),
  .clock_output_o(clock_output_o), .clock_output_pwr_o(clock_output_pwr_o), .clock_output_amp_o(clock_output_amp_o),
  .sysref_capable_output_o(sysref_capable_output_o), .sysref_capable_output_pwr_o(sysref_capable_output_pwr_o),
  .sysref_capable_output_mid_o(sysref_capable_output_mid_o),
  .sysref_capable_output_amp_o(sysref_capable_output_amp_o));
